// ---- hdl/flag_pkg.sv ----
`default_nettype none
package flag_pkg;
   // Queue geometry
   localparam int DATA_W = 36;
   localparam int DEPTH  = 256;
   localparam int OFS_W  = 8;
   // Offset preset loaded at queue reset
   localparam logic [OFS_W-1:0] OFFSET_PRESET = 8'h08;
   // Offset words waiting for the offset registers
   localparam int OFS_FIFO_DEPTH = 4;
   // Clock and skew limits
   localparam int CLK_PERIOD_NS    = 25;
   localparam int FIRST_SKEW_NS    = 5;
   localparam int SECOND_SKEW_NS   = 5;
   localparam int FIRST_SKEW_RAW   = (FIRST_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SECOND_SKEW_RAW  = (SECOND_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIRST_SKEW_CYC   = (FIRST_SKEW_RAW < 1) ? 1 : FIRST_SKEW_RAW;
   localparam int SECOND_SKEW_CYC  = (SECOND_SKEW_RAW < 1) ? 1 : SECOND_SKEW_RAW;
   localparam int SYNC_LEN         = (FIRST_SKEW_CYC > SECOND_SKEW_CYC) ?
                                     FIRST_SKEW_CYC : SECOND_SKEW_CYC;

   typedef struct packed {
      logic full_or_inready;
      logic empty_or_outready;
      logic almost_empty;
      logic almost_full;
   } queue_flags_s;

   typedef struct packed {
      logic [OFS_W-1:0] a_to_b_empty_offset;
      logic [OFS_W-1:0] b_to_a_empty_offset;
      logic [OFS_W-1:0] a_to_b_full_offset;
      logic [OFS_W-1:0] b_to_a_full_offset;
   } offsets_s;
endpackage : flag_pkg
`default_nettype wire

// ---- hdl/dual_clock_fifo_level_flags.sv ----
`default_nettype none

module flag_queue #(
   parameter int WIDTH = flag_pkg::DATA_W,
   parameter int DEPTH = flag_pkg::DEPTH
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   // Mode and thresholds
   input  wire logic                       fall_through,
   input  wire logic [flag_pkg::OFS_W-1:0] empty_offset,
   input  wire logic [flag_pkg::OFS_W-1:0] full_offset,
   // Write side
   input  wire logic                       wr_valid,
   input  wire logic [WIDTH-1:0]           wr_data,
   // Read side
   input  wire logic                       rd_ready,
   output logic      [WIDTH-1:0]           rd_data,
   // Flags
   output var flag_pkg::queue_flags_s      flags
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
   localparam logic [PW-1:0] ZERO_P  = '0;
   localparam int EXT = PW - flag_pkg::OFS_W;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wptr;
   logic [PW-1:0]    rptr;
   logic [PW-1:0]    wsync [flag_pkg::SYNC_LEN];
   logic [PW-1:0]    rsync [flag_pkg::SYNC_LEN];
   logic             mem_nonempty;
   logic             out_valid;
   logic             wr_take;
   logic             shift;
   logic             next_out_valid;
   logic [PW-1:0]    next_wptr;
   logic [PW-1:0]    next_rptr;
   logic [PW-1:0]    rd_fill;
   logic [PW-1:0]    rd_fill_ae;
   logic [PW-1:0]    wr_fill;
   logic [PW-1:0]    wr_fill_af;
   logic [PW-1:0]    ae_level;
   logic [PW-1:0]    af_level;

   // Write acceptance
   assign wr_take   = wr_valid && flags.full_or_inready;
   assign next_wptr = wptr + PW'(wr_take);

   // Output register shift
   always_comb begin
      if (fall_through) begin
         shift = mem_nonempty && (!out_valid || rd_ready);
      end else begin
         shift = mem_nonempty && rd_ready;
      end
   end

   always_comb begin
      if (shift) begin
         next_out_valid = 1'b1;
      end else if (rd_ready && out_valid) begin
         next_out_valid = 1'b0;
      end else begin
         next_out_valid = out_valid;
      end
   end

   assign next_rptr  = rptr + PW'(shift);

   // Fill counts exclude the output register
   assign rd_fill    = wsync[flag_pkg::FIRST_SKEW_CYC-1] - next_rptr;
   assign rd_fill_ae = wsync[flag_pkg::SECOND_SKEW_CYC-1] - next_rptr;
   assign wr_fill    = next_wptr - rsync[flag_pkg::FIRST_SKEW_CYC-1];
   assign wr_fill_af = next_wptr - rsync[flag_pkg::SECOND_SKEW_CYC-1];
   assign ae_level   = {{EXT{1'b0}}, empty_offset};
   assign af_level   = DEPTH_P - {{EXT{1'b0}}, full_offset};

   // Storage
   always_ff @(posedge clk) begin
      if (wr_take) begin
         mem[wptr[AW-1:0]] <= wr_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wptr <= ZERO_P;
         rptr <= ZERO_P;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
      end
   end

   // Pointer hand-over stages between the two sides
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < flag_pkg::SYNC_LEN; i++) begin
            wsync[i] <= ZERO_P;
            rsync[i] <= ZERO_P;
         end
      end else begin
         wsync[0] <= wptr;
         rsync[0] <= rptr;
         for (int i = 1; i < flag_pkg::SYNC_LEN; i++) begin
            wsync[i] <= wsync[i-1];
            rsync[i] <= rsync[i-1];
         end
      end
   end

   // Output register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_data   <= '0;
         out_valid <= 1'b0;
      end else begin
         if (shift) begin
            rd_data <= mem[rptr[AW-1:0]];
         end
         out_valid <= next_out_valid;
      end
   end

   // Read-side and write-side flags
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mem_nonempty <= 1'b0;
         flags        <= '0;
      end else begin
         mem_nonempty <= (rd_fill != ZERO_P);
         if (fall_through) begin
            flags.empty_or_outready <= next_out_valid;
         end else begin
            flags.empty_or_outready <= (rd_fill != ZERO_P);
         end
         flags.almost_empty    <= (rd_fill_ae > ae_level);
         flags.full_or_inready <= (wr_fill < DEPTH_P);
         flags.almost_full     <= (wr_fill_af < af_level);
      end
   end
endmodule : flag_queue

// Short queue for offset words
module word_fifo #(
   parameter int WIDTH = $bits(flag_pkg::offsets_s),
   parameter int DEPTH = flag_pkg::OFS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Input side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Output side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
   localparam logic [PW-1:0] ZERO_P  = '0;

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    head;
   logic [PW-1:0]    tail;
   logic             push;
   logic             pop;

   assign in_ready  = ((tail - head) != DEPTH_P);
   assign out_valid = (tail != head);
   assign out_data  = store[head[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         store[tail[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         head <= ZERO_P;
         tail <= ZERO_P;
      end else begin
         head <= head + PW'(pop);
         tail <= tail + PW'(push);
      end
   end
endmodule : word_fifo

module dual_clock_fifo_level_flags (
   // Clock and reset
   input  wire logic                          mclk_i,
   input  wire logic                          reset_n_i,
   // Mode
   input  wire logic                          fall_through_select_i,
   // Offset programming from port A
   input  wire logic                          offset_load_i,
   input  wire flag_pkg::offsets_s            offset_data_i,
   // Port A
   input  wire logic                          a_wr_valid_i,
   input  wire logic [flag_pkg::DATA_W-1:0]   a_wr_data_i,
   input  wire logic                          a_rd_ready_i,
   output logic      [flag_pkg::DATA_W-1:0]   a_rd_data_o,
   output logic                               porta_full_or_inready_o,
   output logic                               porta_empty_or_outready_o,
   output logic                               porta_almost_empty_o,
   output logic                               porta_almost_full_o,
   // Port B
   input  wire logic                          b_wr_valid_i,
   input  wire logic [flag_pkg::DATA_W-1:0]   b_wr_data_i,
   input  wire logic                          b_rd_ready_i,
   output logic      [flag_pkg::DATA_W-1:0]   b_rd_data_o,
   output logic                               portb_full_or_inready_o,
   output logic                               portb_empty_or_outready_o,
   output logic                               portb_almost_empty_o,
   output logic                               portb_almost_full_o
);
   flag_pkg::offsets_s     offsets;
   flag_pkg::offsets_s     ofs_head;
   logic                   ofs_valid;
   flag_pkg::queue_flags_s a_to_b_flags;
   flag_pkg::queue_flags_s b_to_a_flags;

   // Offset words pass a short queue first
   word_fifo #(
      .WIDTH ($bits(flag_pkg::offsets_s)),
      .DEPTH (flag_pkg::OFS_FIFO_DEPTH)
   ) u_ofs_fifo (
      .clk       (mclk_i),
      .reset_n   (reset_n_i),
      .in_valid  (offset_load_i),
      .in_ready  (),
      .in_data   (offset_data_i),
      .out_valid (ofs_valid),
      .out_ready (1'b1),
      .out_data  (ofs_head)
   );

   // Offset registers
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         offsets.a_to_b_empty_offset <= flag_pkg::OFFSET_PRESET;
         offsets.b_to_a_empty_offset <= flag_pkg::OFFSET_PRESET;
         offsets.a_to_b_full_offset  <= flag_pkg::OFFSET_PRESET;
         offsets.b_to_a_full_offset  <= flag_pkg::OFFSET_PRESET;
      end else if (ofs_valid) begin
         offsets <= ofs_head;
      end
   end

   // Queue from port A to port B
   flag_queue #(
      .WIDTH (flag_pkg::DATA_W),
      .DEPTH (flag_pkg::DEPTH)
   ) u_a_to_b (
      .clk          (mclk_i),
      .reset_n      (reset_n_i),
      .fall_through (fall_through_select_i),
      .empty_offset (offsets.a_to_b_empty_offset),
      .full_offset  (offsets.a_to_b_full_offset),
      .wr_valid     (a_wr_valid_i),
      .wr_data      (a_wr_data_i),
      .rd_ready     (b_rd_ready_i),
      .rd_data      (b_rd_data_o),
      .flags        (a_to_b_flags)
   );

   // Queue from port B to port A
   flag_queue #(
      .WIDTH (flag_pkg::DATA_W),
      .DEPTH (flag_pkg::DEPTH)
   ) u_b_to_a (
      .clk          (mclk_i),
      .reset_n      (reset_n_i),
      .fall_through (fall_through_select_i),
      .empty_offset (offsets.b_to_a_empty_offset),
      .full_offset  (offsets.b_to_a_full_offset),
      .wr_valid     (b_wr_valid_i),
      .wr_data      (b_wr_data_i),
      .rd_ready     (a_rd_ready_i),
      .rd_data      (a_rd_data_o),
      .flags        (b_to_a_flags)
   );

   // Flag routing: write flags to writer, read flags to reader
   assign porta_full_or_inready_o   = a_to_b_flags.full_or_inready;
   assign porta_almost_full_o       = a_to_b_flags.almost_full;
   assign portb_empty_or_outready_o = a_to_b_flags.empty_or_outready;
   assign portb_almost_empty_o      = a_to_b_flags.almost_empty;
   assign portb_full_or_inready_o   = b_to_a_flags.full_or_inready;
   assign portb_almost_full_o       = b_to_a_flags.almost_full;
   assign porta_empty_or_outready_o = b_to_a_flags.empty_or_outready;
   assign porta_almost_empty_o      = b_to_a_flags.almost_empty;
endmodule : dual_clock_fifo_level_flags
`default_nettype wire

// ---- test/flags_chk.sv ----
`default_nettype none
module flags_chk (
   // Clock and reset
   input wire logic                        mclk_i,
   input wire logic                        reset_n_i,
   // Queue from A to B
   input wire logic                        fall_through_select_i,
   input wire logic                        a_wr_valid_i,
   input wire logic                        b_rd_ready_i,
   input wire logic [flag_pkg::DATA_W-1:0] b_rd_data_o,
   // Flags of that queue
   input wire logic                        porta_full_or_inready_o,
   input wire logic                        porta_almost_full_o,
   input wire logic                        portb_empty_or_outready_o,
   input wire logic                        portb_almost_empty_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   full_af_a: assert property (!porta_full_or_inready_o |-> !porta_almost_full_o)
      else $error("full without almost-full");
   empty_ae_a: assert property (!fall_through_select_i && !portb_empty_or_outready_o
      |-> !portb_almost_empty_o) else $error("almost-empty high on empty queue");
   rd_hold_a: assert property (!fall_through_select_i && !portb_empty_or_outready_o
      |=> $stable(b_rd_data_o)) else $error("read data moved while empty");
   full_rise_a: assert property ($rose(porta_full_or_inready_o) && $past(reset_n_i, 4)
      && !fall_through_select_i |-> $past(b_rd_ready_i && portb_empty_or_outready_o, 3))
      else $error("full flag rise not two edges after read");
   af_rise_a: assert property ($rose(porta_almost_full_o) && $past(reset_n_i, 4)
      && !fall_through_select_i |-> $past(b_rd_ready_i && portb_empty_or_outready_o, 3))
      else $error("almost-full rise not two edges after read");
   ae_rise_a: assert property ($rose(portb_almost_empty_o) && $past(reset_n_i, 4)
      |-> $past(a_wr_valid_i && porta_full_or_inready_o, 3))
      else $error("almost-empty rise not two edges after write");
   empty_rise_a: assert property ($rose(portb_empty_or_outready_o) |->
      (fall_through_select_i ? $past(a_wr_valid_i && porta_full_or_inready_o, 4)
      : $past(a_wr_valid_i && porta_full_or_inready_o, 3))) else $error("ready rise late");
   full_fall_a: assert property ($fell(porta_full_or_inready_o)
      |-> $past(a_wr_valid_i && porta_full_or_inready_o, 1)) else $error("full without write");
endmodule : flags_chk
bind dual_clock_fifo_level_flags flags_chk flags_chk_inst (.mclk_i, .reset_n_i,
   .fall_through_select_i, .a_wr_valid_i, .b_rd_ready_i, .b_rd_data_o,
   .porta_full_or_inready_o, .porta_almost_full_o, .portb_empty_or_outready_o,
   .portb_almost_empty_o);
`default_nettype wire

// ---- test/port_reader.sv ----
`default_nettype none
module port_reader (
   // Read wish and stall pattern
   input  wire logic [1:0] go_i,
   input  wire logic [1:0] stall_i,
   // Read requests to both queues
   output wire logic [1:0] rd_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Reader may hold off any cycle
   assign rd_ready_o = go_i & ~stall_i;
endmodule : port_reader
`default_nettype wire

// ---- test/dual_clock_fifo_level_flags_tb.sv ----
`default_nettype none
module dual_clock_fifo_level_flags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'h0, reset_n_i = 1'h0, ft = 1'h0, ld = 1'h0;
   logic [1:0] wv = 2'h0, go = 2'h0, st = 2'h0, have = 2'h0;
   logic [1:0][35:0] wd = '0;
   flag_pkg::offsets_s od = '0;
   wire logic [1:0] rr, full_f, af_f, emp_f, ae_f;
   wire logic [1:0][35:0] rd_f;
   logic [35:0] mq[2][$], last[2];
   int n_fail = 0, checks = 0, seed = 37852, npop[2] = '{0, 0}, xo[2], yo[2], lv[6], m;
   always #12.5 mclk_i = ~mclk_i;
   dual_clock_fifo_level_flags dual_clock_fifo_level_flags_inst (.mclk_i, .reset_n_i,
      .fall_through_select_i(ft), .offset_load_i(ld), .offset_data_i(od),
      .a_wr_valid_i(wv[0]), .a_wr_data_i(wd[0]), .a_rd_ready_i(rr[1]), .a_rd_data_o(rd_f[1]),
      .porta_full_or_inready_o(full_f[0]), .porta_empty_or_outready_o(emp_f[1]),
      .porta_almost_empty_o(ae_f[1]), .porta_almost_full_o(af_f[0]),
      .b_wr_valid_i(wv[1]), .b_wr_data_i(wd[1]), .b_rd_ready_i(rr[0]), .b_rd_data_o(rd_f[0]),
      .portb_full_or_inready_o(full_f[1]), .portb_empty_or_outready_o(emp_f[0]),
      .portb_almost_empty_o(ae_f[0]), .portb_almost_full_o(af_f[1]));
   port_reader port_reader_inst (.go_i(go), .stall_i(st), .rd_ready_o(rr));
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   // Settle, then flags against model fill
   task automatic chk(input int q);
      repeat (6) @(posedge mclk_i);
      #1 m = mq[q].size() - ((ft && mq[q].size() > 0) ? 1 : 0);
      check(full_f[q], m < 256);
      check(af_f[q], m <= 255 - yo[q]);
      check(emp_f[q], mq[q].size() > 0);
      check(ae_f[q], m > xo[q]);
   endtask : chk
   task automatic wr(input int q, input int n);
      for (int i = 0; i < n; i++) begin
         wv[q] = 1'h1;
         wd[q] = 36'($random(seed));
         @(posedge mclk_i);
         #1;
      end
      wv[q] = 1'h0;
   endtask : wr
   task automatic rd(input int q, input int k);
      int t, i;
      t = npop[q] + k;
      go[q] = 1'h1;
      for (i = 0; i < 3000 && npop[q] < t; i++) begin
         st[q] = 1'($random(seed));
         @(posedge mclk_i);
         #1;
      end
      go[q] = 1'h0;
      st[q] = 1'h0;
      if (i == 3000) begin
         check(36'h0, 36'h1);
         final_report();
      end
   endtask : rd
   // Model of both queues
   always @(posedge mclk_i)
      for (int q = 0; q < 2; q++)
         if (reset_n_i) begin
            if (wv[q] && full_f[q] === 1'h1) mq[q].push_back(wd[q]);
            if (rr[q] && emp_f[q] === 1'h1 && mq[q].size() > 0) begin
               last[q] = mq[q].pop_front();
               have[q] = 1'h1;
               npop[q]++;
            end
         end
   always @(negedge mclk_i)
      for (int q = 0; q < 2; q++)
         if (ft ? emp_f[q] === 1'h1 && mq[q].size() > 0 : have[q])
            check(rd_f[q], ft ? mq[q][0] : last[q]);
   initial begin
      for (int f = 0; f < 2; f++) begin
         @(posedge mclk_i);
         #1 reset_n_i = 1'h0;
         ft = f[0];
         have = 2'h0;
         mq[0].delete();
         mq[1].delete();
         od = f ? {8'h03, 8'h04, 8'h05, 8'h06} : {4{flag_pkg::OFFSET_PRESET}};
         repeat (4) @(posedge mclk_i);
         #1 reset_n_i = 1'h1;
         ld = f[0];
         @(posedge mclk_i);
         #1 ld = 1'h0;
         xo = '{od.a_to_b_empty_offset, od.b_to_a_empty_offset};
         yo = '{od.a_to_b_full_offset, od.b_to_a_full_offset};
         for (int q = 0; q < 2; q++) begin
            lv = '{xo[q], xo[q] + 1, 255 - yo[q], 256 - yo[q], 256, 260};
            chk(q);
            foreach (lv[i]) begin
               wr(q, lv[i] + f - mq[q].size());
               chk(q);
            end
            check(mq[q].size(), 256 + f);
            rd(q, 1);
            chk(q);
            rd(q, yo[q]);
            chk(q);
            rd(q, mq[q].size());
            chk(q);
            $display("queue %0d mode %0d done", q, f);
         end
      end
      final_report();
   end
endmodule : dual_clock_fifo_level_flags_tb
`default_nettype wire
